/* File: hdl/tcu_pkg.sv */
package tcu_pkg;
   localparam logic [7:0] TCU_BOTTOM = 8'h00;
   localparam logic [7:0] TCU_MAX = 8'hFF;
   localparam logic [7:0] TCU_ONE = 8'h01;
   // register byte addresses
   localparam logic [11:0] TCU_ADDR_CTRL = 12'h000;
   localparam logic [11:0] TCU_ADDR_COUNT = 12'h004;
   localparam logic [11:0] TCU_ADDR_CMP = 12'h008;
   localparam logic [11:0] TCU_ADDR_FLAGS = 12'h00C;
   localparam logic [11:0] TCU_ADDR_IRQ = 12'h010;
   localparam logic [11:0] TCU_ADDR_PORT = 12'h014;
   // control register fields
   localparam int TCU_CS_LSB = 0;
   localparam int TCU_WGM_LSB = 3;
   localparam int TCU_COM_LSB = 5;
   localparam int TCU_FOC_BIT = 7;
   // flag register fields
   localparam int TCU_OVF_BIT = 0;
   localparam int TCU_CMF_BIT = 1;
   // irq register fields
   localparam int TCU_CIE_BIT = 0;
   localparam int TCU_OIE_BIT = 1;
   localparam int TCU_GIE_BIT = 2;
   localparam int TCU_CACK_BIT = 3;
   localparam int TCU_OACK_BIT = 4;
   // port register fields
   localparam int TCU_PVAL_BIT = 0;
   localparam int TCU_DIR_BIT = 1;
   localparam logic [2:0] TCU_CS_STOP = 3'h0;
   localparam logic [1:0] TCU_COM_NONE = 2'h0;
   localparam logic [1:0] TCU_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCU_COM_CLEAR = 2'h2;
   localparam logic [1:0] TCU_COM_SET = 2'h3;

   typedef enum logic [1:0] {
      TCU_WGM_NORMAL = 2'b00,
      TCU_WGM_PC_PWM = 2'b01,
      TCU_WGM_CTC = 2'b10,
      TCU_WGM_FAST_PWM = 2'b11
   } tcu_wgm_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } tcu_apb_req_t;
endpackage

/* File: hdl/tcu_timer.sv */
// Behaviour
// (RULE1) clock source select zero stops the timer: no count, no clear.
// (RULE2) each timer tick clears, increments or decrements the counter per mode.
// (RULE3) software reads and writes the counter at any time.
// (RULE4) a counter write beats a simultaneous count or clear.
// (RULE5) the two waveform mode bits in the control register pick the sequence.
// (RULE6) overflow flag set per mode and offered as an interrupt source.
// (RULE7) counter and compare value compared continuously; equal means match.
// (RULE8) compare match flag set one timer tick after the match.
// (RULE9) compare irq needs enable and global flag; servicing clears the flag.
// (RULE10) writing one to the compare match flag clears it.
// (RULE11) PWM modes double buffer compare value, update at top or bottom.
// (RULE12) compare accesses reach buffer when buffered, else the active register.
// (RULE13) force strobe in non-PWM modes acts like a match without flag or clear.
// (RULE14) a counter write blocks compare matches in the next timer tick.
// (RULE15) compare output state holds across waveform mode changes.
// (RULE16) output action bits are not buffered and apply at the next match.
// (RULE17) reset clears the compare output state to zero.
// (RULE18) nonzero output action mode routes compare output to the pin.
// (RULE19) the pin override ignores the waveform mode.
// (RULE20) output action mode zero leaves compare output unchanged on match.
// (RULE21) software should avoid writing counter equal to compare value.
// (RULE22) software should set compare output before making the pin an output.
// (RULE23) bottom is 0x00, max is 0xFF, top is max or compare value.
// (RULE24) waveform modes: 0 normal, 1 phase correct, 2 ctc, 3 fast pwm.
module tcu_timer
   import tcu_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic timer_tick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic compare_irq,
   output logic overflow_irq,
   output logic pin_out,
   output logic pin_oe_n
);
   logic rst_meta_r, rst_n_r;
   tcu_apb_req_t req;
   logic [2:0] clock_source_select_r;
   tcu_wgm_t waveform_mode_r;
   logic [1:0] output_action_mode_r;
   logic [7:0] counter_value_r, compare_value_r, compare_buf_r;
   logic overflow_flag_r, compare_match_flag_r, match_pending_r, block_r;
   logic compare_output_r, compare_irq_enable_r, ovf_irq_enable_r, global_irq_r;
   logic port_value_r, output_pin_direction_bit_r, dir_down_r;
   logic wr, rd, tick, is_pwm, match, force_cmp, cnt_wr, cmp_wr, ctrl_wr;
   logic flag_wr, irq_wr, port_wr, at_top, at_bottom, ovf_set, upd_cmp, unmapped;
   logic [7:0] cnt_nxt;
   logic oc_nxt, dir_nxt;
   logic [1:0] com_eff;

   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] b);
      addr_hit = (a == b);
   endfunction

   // reset release through two flops; the async edge only clears
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
   // zero wait states: every access completes in its first access cycle
   assign wr = psel && penable && req.pwrite;
   assign rd = psel && penable && !req.pwrite;
   assign ctrl_wr = wr && addr_hit(req.paddr, TCU_ADDR_CTRL);
   assign cnt_wr = wr && addr_hit(req.paddr, TCU_ADDR_COUNT);
   assign cmp_wr = wr && addr_hit(req.paddr, TCU_ADDR_CMP);
   assign flag_wr = wr && addr_hit(req.paddr, TCU_ADDR_FLAGS);
   assign irq_wr = wr && addr_hit(req.paddr, TCU_ADDR_IRQ);
   assign port_wr = wr && addr_hit(req.paddr, TCU_ADDR_PORT);
   assign unmapped = !(addr_hit(req.paddr, TCU_ADDR_CTRL) || addr_hit(req.paddr, TCU_ADDR_COUNT)
      || addr_hit(req.paddr, TCU_ADDR_CMP) || addr_hit(req.paddr, TCU_ADDR_FLAGS)
      || addr_hit(req.paddr, TCU_ADDR_IRQ) || addr_hit(req.paddr, TCU_ADDR_PORT));

   assign tick = timer_tick && (clock_source_select_r != TCU_CS_STOP); // RULE1
   assign is_pwm = (waveform_mode_r == TCU_WGM_PC_PWM) || (waveform_mode_r == TCU_WGM_FAST_PWM);
   assign match = (counter_value_r == compare_value_r); // RULE7
   assign force_cmp = ctrl_wr && req.pwdata[TCU_FOC_BIT] && !is_pwm; // RULE13
   assign at_bottom = (counter_value_r == TCU_BOTTOM); // RULE23
   assign at_top = (waveform_mode_r == TCU_WGM_CTC) ? match : (counter_value_r == TCU_MAX);

   // counting sequence per mode
   always_comb begin
      cnt_nxt = counter_value_r;
      dir_nxt = dir_down_r;
      ovf_set = 1'b0;
      upd_cmp = 1'b0;
      case (waveform_mode_r) // RULE5 RULE24
         TCU_WGM_NORMAL: begin
            cnt_nxt = counter_value_r + TCU_ONE; // RULE2
            ovf_set = (counter_value_r == TCU_MAX); // RULE6
         end
         TCU_WGM_CTC: begin
            if (match) begin
               cnt_nxt = TCU_BOTTOM; // RULE2
            end else begin
               cnt_nxt = counter_value_r + TCU_ONE;
            end
            ovf_set = (counter_value_r == TCU_MAX);
         end
         TCU_WGM_FAST_PWM: begin
            cnt_nxt = counter_value_r + TCU_ONE;
            ovf_set = (counter_value_r == TCU_MAX);
            upd_cmp = (counter_value_r == TCU_MAX); // RULE11
         end
         TCU_WGM_PC_PWM: begin
            if (at_top) begin
               dir_nxt = 1'b1;
               upd_cmp = 1'b1; // RULE11
            end else if (at_bottom) begin
               dir_nxt = 1'b0;
            end
            if (at_top || (dir_down_r && !at_bottom)) begin
               cnt_nxt = counter_value_r - TCU_ONE; // RULE2
            end else begin
               cnt_nxt = counter_value_r + TCU_ONE;
            end
            ovf_set = at_bottom && dir_down_r;
         end
         default: begin
            cnt_nxt = counter_value_r;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         counter_value_r <= TCU_BOTTOM;
         dir_down_r <= 1'b0;
      end else if (cnt_wr) begin
         counter_value_r <= req.pwdata[7:0]; // RULE3 RULE4
      end else if (tick) begin
         counter_value_r <= cnt_nxt;
         dir_down_r <= dir_nxt;
      end
   end

   // block stays armed until the next timer tick, even if stopped
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         block_r <= 1'b0;
      end else if (cnt_wr) begin
         block_r <= 1'b1; // RULE14
      end else if (tick) begin
         block_r <= 1'b0;
      end
   end

   // match seen on one tick sets the flag on the following tick
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         match_pending_r <= 1'b0;
      end else if (tick) begin
         match_pending_r <= match && !block_r && !cnt_wr; // RULE8 RULE14
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         clock_source_select_r <= TCU_CS_STOP;
         waveform_mode_r <= TCU_WGM_NORMAL;
         output_action_mode_r <= TCU_COM_NONE;
      end else if (ctrl_wr) begin
         clock_source_select_r <= req.pwdata[TCU_CS_LSB +: 3];
         waveform_mode_r <= tcu_wgm_t'(req.pwdata[TCU_WGM_LSB +: 2]);
         output_action_mode_r <= req.pwdata[TCU_COM_LSB +: 2]; // RULE16
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         compare_value_r <= TCU_BOTTOM;
         compare_buf_r <= TCU_BOTTOM;
      end else begin
         if (cmp_wr) begin
            compare_buf_r <= req.pwdata[7:0]; // RULE12
         end
         if (cmp_wr && !is_pwm) begin
            compare_value_r <= req.pwdata[7:0]; // RULE11 RULE12
         end else if (is_pwm && tick && upd_cmp && !cnt_wr) begin
            compare_value_r <= compare_buf_r; // RULE11
         end
      end
   end

   // a control write's action bits apply at once, so a force in that same write uses them
   assign com_eff = ctrl_wr ? req.pwdata[TCU_COM_LSB +: 2] : output_action_mode_r; // RULE16

   // compare output state; fast/phase pwm actions kept simple: match sets or clears
   always_comb begin
      oc_nxt = compare_output_r;
      case (com_eff) // RULE20
         TCU_COM_TOGGLE: oc_nxt = is_pwm ? compare_output_r : !compare_output_r;
         TCU_COM_CLEAR: oc_nxt = (waveform_mode_r == TCU_WGM_PC_PWM) ? dir_down_r : 1'b0;
         TCU_COM_SET: oc_nxt = (waveform_mode_r == TCU_WGM_PC_PWM) ? !dir_down_r : 1'b1;
         default: oc_nxt = compare_output_r;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         compare_output_r <= 1'b0; // RULE17
      end else if (force_cmp) begin
         compare_output_r <= oc_nxt; // RULE13
      end else if (tick && !cnt_wr && match && !block_r) begin
         compare_output_r <= oc_nxt; // RULE15 RULE16
      end else if (tick && !cnt_wr && waveform_mode_r == TCU_WGM_FAST_PWM
                   && counter_value_r == TCU_MAX && output_action_mode_r[1]) begin
         compare_output_r <= !output_action_mode_r[0];
      end
   end

   // set wins over a software or service clear
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         compare_match_flag_r <= 1'b0;
         overflow_flag_r <= 1'b0;
      end else begin
         if (tick && match_pending_r) begin
            compare_match_flag_r <= 1'b1; // RULE8
         end else if ((flag_wr && req.pwdata[TCU_CMF_BIT])
                      || (irq_wr && req.pwdata[TCU_CACK_BIT])) begin
            compare_match_flag_r <= 1'b0; // RULE9 RULE10
         end
         if (tick && !cnt_wr && ovf_set) begin
            overflow_flag_r <= 1'b1; // RULE6
         end else if ((flag_wr && req.pwdata[TCU_OVF_BIT])
                      || (irq_wr && req.pwdata[TCU_OACK_BIT])) begin
            overflow_flag_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         compare_irq_enable_r <= 1'b0;
         ovf_irq_enable_r <= 1'b0;
         global_irq_r <= 1'b0;
         port_value_r <= 1'b0;
         output_pin_direction_bit_r <= 1'b0;
      end else begin
         if (irq_wr) begin
            compare_irq_enable_r <= req.pwdata[TCU_CIE_BIT];
            ovf_irq_enable_r <= req.pwdata[TCU_OIE_BIT];
            global_irq_r <= req.pwdata[TCU_GIE_BIT];
         end
         if (port_wr) begin
            port_value_r <= req.pwdata[TCU_PVAL_BIT];
            output_pin_direction_bit_r <= req.pwdata[TCU_DIR_BIT];
         end
      end
   end

   // outputs registered; they lag their sources by one clock
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         compare_irq <= 1'b0;
         overflow_irq <= 1'b0;
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         compare_irq <= compare_match_flag_r && compare_irq_enable_r && global_irq_r; // RULE9
         overflow_irq <= overflow_flag_r && ovf_irq_enable_r && global_irq_r; // RULE6
         pin_out <= (output_action_mode_r != TCU_COM_NONE) ? compare_output_r
                    : port_value_r; // RULE18 RULE19
         pin_oe_n <= !output_pin_direction_bit_r; // RULE18
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && unmapped;
         prdata <= 32'h00000000;
         if (psel && !penable && !req.pwrite) begin
            case (req.paddr)
               TCU_ADDR_CTRL: prdata <= {24'h000000, 1'b0, output_action_mode_r,
                                         waveform_mode_r, clock_source_select_r};
               TCU_ADDR_COUNT: prdata <= {24'h000000, counter_value_r}; // RULE3
               TCU_ADDR_CMP: prdata <= {24'h000000,
                                        is_pwm ? compare_buf_r : compare_value_r}; // RULE12
               TCU_ADDR_FLAGS: prdata <= {30'h00000000, compare_match_flag_r, overflow_flag_r};
               TCU_ADDR_IRQ: prdata <= {29'h00000000, global_irq_r, ovf_irq_enable_r,
                                        compare_irq_enable_r};
               TCU_ADDR_PORT: prdata <= {30'h00000000, output_pin_direction_bit_r,
                                         port_value_r};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // assertions
   stop_holds_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE1
      (clock_source_select_r == TCU_CS_STOP && !cnt_wr) |=> $stable(counter_value_r))
      else $error("counter moved while stopped");
   write_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE4
      cnt_wr |=> counter_value_r == $past(req.pwdata[7:0]))
      else $error("counter write lost");
   normal_inc_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE2
      (tick && !cnt_wr && waveform_mode_r == TCU_WGM_NORMAL)
      |=> counter_value_r == $past(counter_value_r) + TCU_ONE)
      else $error("normal mode did not increment");
   ctc_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE2
      (tick && !cnt_wr && waveform_mode_r == TCU_WGM_CTC && match)
      |=> counter_value_r == TCU_BOTTOM)
      else $error("ctc mode did not clear on match");
   pc_turn_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE2
      (tick && !cnt_wr && waveform_mode_r == TCU_WGM_PC_PWM && counter_value_r == TCU_MAX)
      |=> counter_value_r == TCU_MAX - TCU_ONE)
      else $error("phase correct count did not turn at max");
   buf_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE11
      (tick && !cnt_wr && waveform_mode_r == TCU_WGM_PC_PWM && counter_value_r == TCU_MAX)
      |=> compare_value_r == $past(compare_buf_r))
      else $error("compare buffer not loaded at top");
   cmp_direct_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE12
      (cmp_wr && !is_pwm) |=> compare_value_r == $past(req.pwdata[7:0]))
      else $error("unbuffered compare write lost");
   sequence s_match_tick;
      tick && !cnt_wr && match && !block_r;
   endsequence
   sequence s_pending_tick;
      tick && match_pending_r;
   endsequence
   match_pend_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE8
      s_match_tick |=> match_pending_r)
      else $error("match not held for the next tick");
   flag_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE8
      s_pending_tick |=> compare_match_flag_r)
      else $error("match flag not set one tick later");
   flag_late_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE8
      (tick && !match_pending_r && !compare_match_flag_r) |=> !compare_match_flag_r)
      else $error("match flag set in the match tick");
   block_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE14
      cnt_wr |=> block_r)
      else $error("counter write did not arm the block");
   block_next_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE14
      (tick && block_r) |=> !match_pending_r)
      else $error("match not blocked after counter write");
   flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE10
      (flag_wr && req.pwdata[TCU_CMF_BIT] && !(tick && match_pending_r))
      |=> !compare_match_flag_r)
      else $error("write one did not clear flag");
   irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE9
      compare_irq |-> $past(compare_match_flag_r && compare_irq_enable_r && global_irq_r))
      else $error("compare irq without enable");
   force_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE13
      (force_cmp && com_eff == TCU_COM_SET) |=> compare_output_r)
      else $error("forced set did not set compare output");
   com_none_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE20
      (output_action_mode_r == TCU_COM_NONE && com_eff == TCU_COM_NONE
       && waveform_mode_r != TCU_WGM_FAST_PWM) |=> $stable(compare_output_r))
      else $error("compare output moved with no action");
   pin_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE18
      (output_action_mode_r != TCU_COM_NONE) |=> pin_out == $past(compare_output_r))
      else $error("pin not driven by compare output");
   oe_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n_r) // RULE18
      pin_oe_n == !$past(output_pin_direction_bit_r))
      else $error("pin enable does not follow direction bit");
endmodule

/* File: tb/tcu_cpu_model.sv */
module tcu_cpu_model
   import tcu_pkg::*;
(
   input wire logic clk_sys,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end

   // one transfer; the request stands until pready is sampled high or 16 access cycles pass
   task automatic xfer(input tcu_apb_req_t req, output logic [31:0] rdata,
                       output logic err, output bit ok);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= req.pwrite;
      paddr <= req.paddr;
      pwdata <= req.pwdata;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      ok = (pready === 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines change, so a stale value cannot pass for a held one
      pwdata <= ~req.pwdata;
   endtask
endmodule

/* File: tb/timer8_counter_compare_unit_test.sv */
module timer8_counter_compare_unit_test;
   import tcu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys, arst_n, timer_tick, psel, penable, pwrite, pready, pslverr;
   logic compare_irq, overflow_irq, pin_out, pin_oe_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   int error_cnt, num_checks;

   tcu_timer u_tcu_timer (.clk_sys(clk_sys), .arst_n(arst_n), .timer_tick(timer_tick),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_irq(compare_irq),
      .overflow_irq(overflow_irq), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

   tcu_cpu_model u_tcu_cpu_model (.clk_sys(clk_sys), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic test_done;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      tcu_apb_req_t q;
      bit ok;
      q = '{paddr: a, pwrite: w, pwdata: d};
      u_tcu_cpu_model.xfer(q, r, e, ok);
      if (!ok) begin
         error_cnt++;
         $display("CHECK FAILED pready expected 1 seen 0");
         test_done();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      acc(a, 1'b1, d, r, e);
   endtask

   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      acc(a, 1'b0, 32'h00000000, r, e);
      chk(what, exp, r);
   endtask

   // spaced single-cycle tick pulses, then time for flags and irqs to land
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         timer_tick <= 1'b1;
         @(posedge clk_sys);
         timer_tick <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
   endtask

   function automatic logic [31:0] ctl(logic [2:0] cs, logic [1:0] wgm, logic [1:0] com,
                                       logic foc);
      ctl = 32'(cs) << TCU_CS_LSB | 32'(wgm) << TCU_WGM_LSB | 32'(com) << TCU_COM_LSB
         | 32'(foc) << TCU_FOC_BIT;
   endfunction

   initial begin
      logic [31:0] r;
      logic e;
      logic oc;
      logic [7:0] ctc_seq [4];
      ctc_seq = '{8'h01, 8'h02, 8'h03, 8'h00};
      error_cnt = 0;
      num_checks = 0;
      timer_tick = 1'b0;
      arst_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      chk("pin_oe_n in reset", 32'h1, 32'(pin_oe_n));
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd("ctrl reset", TCU_ADDR_CTRL, 32'h0);
      rd("flags reset", TCU_ADDR_FLAGS, 32'h0);
      // overflow in normal mode; stopped timer first
      wr(TCU_ADDR_CMP, 32'h05);
      wr(TCU_ADDR_COUNT, 32'hFE);
      ticks(2);
      rd("count stopped", TCU_ADDR_COUNT, 32'hFE);
      wr(TCU_ADDR_CTRL, ctl(3'h1, TCU_WGM_NORMAL, TCU_COM_NONE, 1'b0));
      ticks(1);
      rd("count up", TCU_ADDR_COUNT, 32'hFF);
      ticks(1);
      rd("count wrap", TCU_ADDR_COUNT, 32'h00);
      rd("ovf flag", TCU_ADDR_FLAGS, 32'h1);
      wr(TCU_ADDR_IRQ, 32'h6);
      ticks(0);
      chk("overflow_irq", 32'h1, 32'(overflow_irq));
      wr(TCU_ADDR_IRQ, 32'h16);
      ticks(0);
      chk("overflow_irq ack", 32'h0, 32'(overflow_irq));
      // compare flag one tick late, irq gating and service clear
      wr(TCU_ADDR_COUNT, 32'h03);
      ticks(2);
      rd("cmf same tick", TCU_ADDR_FLAGS, 32'h0);
      ticks(2);
      rd("cmf set", TCU_ADDR_FLAGS, 32'h2);
      wr(TCU_ADDR_IRQ, 32'h1);
      ticks(0);
      chk("compare_irq no global", 32'h0, 32'(compare_irq));
      wr(TCU_ADDR_IRQ, 32'h5);
      ticks(0);
      chk("compare_irq", 32'h1, 32'(compare_irq));
      wr(TCU_ADDR_IRQ, 32'hD);
      ticks(0);
      chk("compare_irq serviced", 32'h0, 32'(compare_irq));
      rd("cmf serviced", TCU_ADDR_FLAGS, 32'h0);
      wr(TCU_ADDR_IRQ, 32'h0);
      wr(TCU_ADDR_COUNT, 32'h04);
      ticks(3);
      wr(TCU_ADDR_FLAGS, 32'h2);
      rd("cmf w1c", TCU_ADDR_FLAGS, 32'h0);
      // counter written equal to compare value on purpose
      wr(TCU_ADDR_CMP, 32'h20);
      wr(TCU_ADDR_COUNT, 32'h20);
      ticks(3);
      rd("blocked match", TCU_ADDR_FLAGS, 32'h0);
      rd("count after block", TCU_ADDR_COUNT, 32'h23);
      // write lands on the same edge as a tick
      fork
         wr(TCU_ADDR_COUNT, 32'h77);
         begin
            repeat (2) @(posedge clk_sys);
            timer_tick <= 1'b1;
            @(posedge clk_sys);
            timer_tick <= 1'b0;
         end
      join
      rd("write beats count", TCU_ADDR_COUNT, 32'h77);
      // forced compare actions, stopped timer
      wr(TCU_ADDR_CTRL, ctl(3'h0, TCU_WGM_NORMAL, TCU_COM_TOGGLE, 1'b0));
      ticks(0);
      chk("pin_out after reset", 32'h0, 32'(pin_out));
      oc = 1'b0;
      for (int c = 1; c < 4; c++) begin
         wr(TCU_ADDR_CTRL, ctl(3'h0, TCU_WGM_NORMAL, 2'(c), 1'b1));
         oc = (c == 1) ? ~oc : c[0];
         ticks(0);
         chk("pin_out forced", 32'(oc), 32'(pin_out));
      end
      // compare output set up before the pin becomes an output
      wr(TCU_ADDR_PORT, 32'h2);
      ticks(0);
      chk("pin_oe_n", 32'h0, 32'(pin_oe_n));
      rd("force no flag", TCU_ADDR_FLAGS, 32'h0);
      rd("force no clear", TCU_ADDR_COUNT, 32'h77);
      wr(TCU_ADDR_CTRL, ctl(3'h0, TCU_WGM_NORMAL, TCU_COM_NONE, 1'b1));
      ticks(0);
      chk("pin_out port value", 32'h0, 32'(pin_out));
      wr(TCU_ADDR_CTRL, ctl(3'h0, TCU_WGM_NORMAL, TCU_COM_TOGGLE, 1'b0));
      ticks(0);
      chk("pin_out com zero kept", 32'h1, 32'(pin_out));
      wr(TCU_ADDR_CTRL, ctl(3'h0, TCU_WGM_FAST_PWM, TCU_COM_CLEAR, 1'b0));
      ticks(0);
      chk("pin_out mode change", 32'h1, 32'(pin_out));
      // fast pwm buffers the compare value
      wr(TCU_ADDR_CTRL, ctl(3'h1, TCU_WGM_FAST_PWM, TCU_COM_NONE, 1'b0));
      wr(TCU_ADDR_CMP, 32'h31);
      rd("cmp buffer", TCU_ADDR_CMP, 32'h31);
      wr(TCU_ADDR_COUNT, 32'h30);
      ticks(3);
      rd("no match on buffer", TCU_ADDR_FLAGS, 32'h0);
      // clear on compare match, direct compare access
      wr(TCU_ADDR_CTRL, ctl(3'h1, TCU_WGM_CTC, TCU_COM_NONE, 1'b0));
      wr(TCU_ADDR_CMP, 32'h03);
      rd("cmp direct", TCU_ADDR_CMP, 32'h03);
      wr(TCU_ADDR_COUNT, 32'h00);
      foreach (ctc_seq[i]) begin
         ticks(1);
         rd("ctc count", TCU_ADDR_COUNT, 32'(ctc_seq[i]));
      end
      wr(TCU_ADDR_CTRL, ctl(TCU_CS_STOP, TCU_WGM_CTC, TCU_COM_NONE, 1'b0));
      ticks(3);
      rd("ctc stopped", TCU_ADDR_COUNT, 32'h00);
      // phase correct turns down at max and loads the buffered compare value there
      wr(TCU_ADDR_CTRL, ctl(3'h1, TCU_WGM_PC_PWM, TCU_COM_NONE, 1'b0));
      wr(TCU_ADDR_CMP, 32'h40);
      wr(TCU_ADDR_COUNT, 32'hFE);
      ticks(2);
      rd("pc count down", TCU_ADDR_COUNT, 32'hFE);
      wr(TCU_ADDR_CTRL, ctl(TCU_CS_STOP, TCU_WGM_NORMAL, TCU_COM_NONE, 1'b0));
      rd("cmp loaded at top", TCU_ADDR_CMP, 32'h40);
      acc(12'h020, 1'b0, 32'h0, r, e);
      chk("unmapped pslverr", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, r);
      test_done();
   end
endmodule
